//--- ccrl_cfg.svh
// register offsets, field positions, reset values and timing counts of the level/route control
`ifndef CCRL_CFG_SVH
`define CCRL_CFG_SVH

`define CCRL_OFS_DAC2_CTRL    8'h0c
`define CCRL_OFS_OUT1         8'h0d
`define CCRL_OFS_OUT2         8'h0e
`define CCRL_OFS_OUT3         8'h0f
`define CCRL_OFS_ADC_LEFT     8'h10
`define CCRL_OFS_ADC_RIGHT    8'h11
`define CCRL_OFS_DAC2_VOL_A   8'h14
`define CCRL_OFS_DAC2_VOL_B   8'h15

`define CCRL_BIT_DEEMPH       7
`define CCRL_BIT_SNGVOL       6
`define CCRL_BIT_SOFT         5
`define CCRL_BIT_ZC           4
`define CCRL_BIT_LOOPBACK     3
`define CCRL_BIT_INVERT       2
`define CCRL_POS_MIX          0
`define CCRL_BIT_EXT_MUTE     3
`define CCRL_POS_SRC_SEL      0

`define CCRL_RST_DAC2_CTRL    8'h00
`define CCRL_RST_OUT          8'h07
`define CCRL_RST_ADC_VOL      8'h00
`define CCRL_RST_DAC2_VOL     8'h00

`define CCRL_ADC_VOL_MAX      8'h18
`define CCRL_ADC_VOL_LOW      8'h58
`define CCRL_ADC_LOW_HALF_DB  (-168)
`define CCRL_ZC_TIMEOUT_MIN   512
`define CCRL_ZC_TIMEOUT_MAX   1024
`define CCRL_STEPS_PER_DB     8
`define CCRL_FRAMES_PER_DB    8
`define CCRL_FRAMES_PER_STEP  (`CCRL_FRAMES_PER_DB / `CCRL_STEPS_PER_DB)

`endif

//--- ccrl_pkg.sv
// types of the level/route control block
package ccrl_pkg;

   typedef enum logic [1:0] {
      CCRL_MIX_STEREO = 2'b00,
      CCRL_MIX_MONO   = 2'b01,
      CCRL_MIX_MONO_B = 2'b10,
      CCRL_MIX_SWAP   = 2'b11
   } ccrl_mix_e;

   typedef struct packed {
      logic      deemph;
      logic      second_dac_single_volume;
      logic      second_dac_soft_ramp_en;
      logic      second_dac_zero_cross_en;
      logic      loopback_en;
      logic      second_dac_invert;
      ccrl_mix_e second_dac_mixer_sel;
   } ccrl_dac2_ctrl_s;

   typedef struct packed {
      logic [3:0] rsvd;
      logic       ext_mute;
      logic [2:0] source_sel;
   } ccrl_out_ctrl_s;

   typedef struct packed {
      logic       valid;
      logic [2:0] source_sel;
   } ccrl_route_s;

   typedef struct packed {
      logic data;
      logic bit_clock;
      logic frame_clock;
   } ccrl_serial_s;

endpackage

//--- ccrl_level_ramp.sv
// per-channel level engine: immediate, zero-cross, soft-ramp and combined modes
`timescale 1ns/10ps
`include "ccrl_cfg.svh"
module ccrl_level_ramp #(
   parameter int LEVEL_W = 11,
   parameter int TIMEOUT = `CCRL_ZC_TIMEOUT_MIN
) (
   // clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_sys_rst,
   // mode and pacing
   input  wire logic                      i_soft,
   input  wire logic                      i_zc,
   input  wire logic                      i_tick,
   input  wire logic                      i_zero_cross,
   // levels in 1/8 dB units
   input  wire logic signed [LEVEL_W-1:0] i_target,
   output logic signed [LEVEL_W-1:0]      o_level
);
   initial begin
      if (TIMEOUT < `CCRL_ZC_TIMEOUT_MIN || TIMEOUT > `CCRL_ZC_TIMEOUT_MAX || LEVEL_W < 11)
         $error("ccrl_level_ramp: unsupported parameters");
   end

   logic [10:0] wait_cnt;
   logic        pending;
   logic        timed_out;
   logic        step_ok;

   assign pending   = (i_target != o_level);
   assign timed_out = i_tick && (wait_cnt >= 11'(TIMEOUT - 1));
   // a step is only ever taken on a frame edge so soft ramp paces at one 1/8 dB per frame
   assign step_ok   = i_zc ? ((i_tick && i_zero_cross) || timed_out) : i_tick;

   // each instance owns its timer, so channels never wait on each other
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_cnt <= 11'h000;
      end else if (!pending || step_ok) begin
         wait_cnt <= 11'h000;
      end else if (i_tick) begin
         wait_cnt <= wait_cnt + 11'h001;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_level <= '0;
      end else if (!i_soft && !i_zc) begin
         o_level <= i_target;
      end else if (pending && step_ok) begin
         if (!i_soft) begin
            o_level <= i_target;
         end else if (i_target > o_level) begin
            o_level <= o_level + LEVEL_W'(1);
         end else begin
            o_level <= o_level - LEVEL_W'(1);
         end
      end
   end

   a_immediate_apply: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (!i_soft && !i_zc) |=> (o_level == $past(i_target)))
      else $error("level not applied at once with both modes off");
   a_ramp_step_size: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_soft |=> ((o_level == $past(o_level)) || (o_level == $past(o_level) + LEVEL_W'(1))
                  || (o_level == $past(o_level) - LEVEL_W'(1))))
      else $error("soft ramp moved more than one eighth dB");
   a_ramp_frame_paced: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      ((i_soft || i_zc) && !i_tick) |=> $stable(o_level))
      else $error("level moved between frame edges");
   a_zc_gate_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_zc && i_tick && !i_zero_cross && !timed_out) |=> $stable(o_level))
      else $error("zero-cross gate let a change through early");
   a_zc_timeout_bound: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      wait_cnt <= 11'(TIMEOUT - 1))
      else $error("zero-cross wait exceeded the timeout");
   c_ramp_step: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_soft && pending && step_ok);
   c_zc_timeout: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_zc && pending && timed_out);
endmodule // ccrl_level_ramp

//--- ccrl_top.sv
// control registers, second-DAC processing, output routing and ADC volume levels
//
// Operation
// - single-volume on: channel A volume drives both second-DAC channels, B ignored.
// - soft ramp moves level in 1/8 dB steps, 1 dB per 8 frames.
// - zero-cross mode applies change at a zero crossing or after 512-1024 samples.
// - zero-cross detection and timeout run separately for each channel.
// - soft plus zero-cross: each 1/8 dB step waits for crossing or timeout.
// - both mode bits clear: level change applies immediately.
// - loopback routes ADC data, bit clock and frame clock into first DAC port.
// - invert negates both second-DAC channels, 180 degree phase shift.
// - mixer: 00 straight, 01 mono average on both, 11 swapped.
// - external mute bit 1 drives active-low pin low, 0 drives it high.
// - source selector: 001-101 input pairs, 110 first DAC, 111 second DAC.
// - each ADC channel has its own 8-bit half-dB volume, soft ramp optional.
// - ADC volume decodes two's complement half-dB, +12 to -84 dB.
// - second-DAC volume is unsigned half-dB attenuation, 0 to -127.5 dB.
`timescale 1ns/10ps
`include "ccrl_cfg.svh"
module ccrl_top #(
   parameter int SAMPLE_W   = 24,
   parameter int LEVEL_W    = 11,
   parameter int ZC_TIMEOUT = `CCRL_ZC_TIMEOUT_MIN
) (
   // clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_sys_rst,
   // control port
   input  wire logic                       i_reg_wr,
   input  wire logic                       i_reg_rd,
   input  wire logic [7:0]                 i_reg_addr,
   input  wire logic [7:0]                 i_reg_wdata,
   output logic [7:0]                      o_reg_rdata,
   // neighbouring ADC soft-ramp enable
   input  wire logic                       i_adc_soft_ramp_en,
   // second-DAC sample stream, paced by the frame clock
   input  wire logic                       i_frame_clock,
   input  wire logic signed [SAMPLE_W-1:0] i_dac2_left,
   input  wire logic signed [SAMPLE_W-1:0] i_dac2_right,
   output logic signed [SAMPLE_W-1:0]      o_dac2_a,
   output logic signed [SAMPLE_W-1:0]      o_dac2_b,
   output logic signed [LEVEL_W-1:0]       o_dac2_level_a,
   output logic signed [LEVEL_W-1:0]       o_dac2_level_b,
   output logic signed [LEVEL_W-1:0]       o_adc_level_left,
   output logic signed [LEVEL_W-1:0]       o_adc_level_right,
   // serial port sources for the first DAC
   input  ccrl_pkg::ccrl_serial_s          i_adc_port,
   input  ccrl_pkg::ccrl_serial_s          i_dac1_pins,
   output ccrl_pkg::ccrl_serial_s          o_dac1_port,
   // analog outputs
   output logic [2:0]                      o_output_ext_mute_n,
   output ccrl_pkg::ccrl_route_s [2:0]     o_output_route
);
   initial begin
      if (SAMPLE_W < 2 || LEVEL_W < 11)
         $error("ccrl_top: unsupported parameters");
   end

   ccrl_pkg::ccrl_dac2_ctrl_s      dac2_ctrl;
   ccrl_pkg::ccrl_out_ctrl_s [2:0] out_ctrl;
   logic [7:0]                     adc_vol [2];
   logic [7:0]                     dac2_vol [2];
   logic signed [LEVEL_W-1:0]      adc_target [2];
   logic signed [LEVEL_W-1:0]      chan_target [4];
   logic signed [LEVEL_W-1:0]      chan_level [4];
   logic [3:0]                     chan_soft;
   logic [3:0]                     chan_zc;
   logic [3:0]                     chan_cross;
   logic                           frame_prev;
   logic                           tick;
   logic signed [SAMPLE_W-1:0]     next_a;
   logic signed [SAMPLE_W-1:0]     next_b;
   logic signed [SAMPLE_W:0]       sum_lr;
   logic signed [SAMPLE_W-1:0]     mono;

   // a write to 0x0d..0x0f takes effect on the next edge; reserved bits are dropped
   function automatic logic out_reg_hit(input logic [7:0] addr, input int idx);
      return addr == (`CCRL_OFS_OUT1 + 8'(idx));
   endfunction

   // reserved ADC codes decode as invalid and leave the previous target in place
   function automatic logic adc_code_ok(input logic [7:0] code);
      return (code <= `CCRL_ADC_VOL_MAX) || code[7] || (code == `CCRL_ADC_VOL_LOW);
   endfunction

   function automatic logic signed [LEVEL_W-1:0] adc_decode(input logic [7:0] code);
      logic signed [LEVEL_W-1:0] half_db;
      half_db = (code == `CCRL_ADC_VOL_LOW) ? LEVEL_W'(`CCRL_ADC_LOW_HALF_DB)
                                             : LEVEL_W'($signed(code));
      return LEVEL_W'(half_db * 4);
   endfunction

   // negating the most negative code would wrap, so it saturates instead
   function automatic logic signed [SAMPLE_W-1:0] negate(input logic signed [SAMPLE_W-1:0] s);
      logic signed [SAMPLE_W-1:0] most_neg;
      most_neg = {1'b1, {(SAMPLE_W-1){1'b0}}};
      return (s == most_neg) ? ~s : -s;
   endfunction

   function automatic logic crossed(input logic signed [SAMPLE_W-1:0] prev,
                                    input logic signed [SAMPLE_W-1:0] cur);
      return (cur == '0) || (prev[SAMPLE_W-1] != cur[SAMPLE_W-1]);
   endfunction

   // register writes
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dac2_ctrl <= ccrl_pkg::ccrl_dac2_ctrl_s'(`CCRL_RST_DAC2_CTRL);
      end else if (i_reg_wr && i_reg_addr == `CCRL_OFS_DAC2_CTRL) begin
         dac2_ctrl <= ccrl_pkg::ccrl_dac2_ctrl_s'(i_reg_wdata);
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         adc_vol[0]  <= `CCRL_RST_ADC_VOL;
         adc_vol[1]  <= `CCRL_RST_ADC_VOL;
         dac2_vol[0] <= `CCRL_RST_DAC2_VOL;
         dac2_vol[1] <= `CCRL_RST_DAC2_VOL;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            `CCRL_OFS_ADC_LEFT:   adc_vol[0]  <= i_reg_wdata;
            `CCRL_OFS_ADC_RIGHT:  adc_vol[1]  <= i_reg_wdata;
            `CCRL_OFS_DAC2_VOL_A: dac2_vol[0] <= i_reg_wdata;
            `CCRL_OFS_DAC2_VOL_B: dac2_vol[1] <= i_reg_wdata;
            default: begin
            end
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_out
         always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               out_ctrl[g] <= ccrl_pkg::ccrl_out_ctrl_s'(`CCRL_RST_OUT);
            end else if (i_reg_wr && out_reg_hit(i_reg_addr, g)) begin
               out_ctrl[g] <= {4'h0, i_reg_wdata[`CCRL_BIT_EXT_MUTE],
                               i_reg_wdata[`CCRL_POS_SRC_SEL +: 3]};
            end
         end

         always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               o_output_ext_mute_n[g] <= 1'b1;
               o_output_route[g]      <= '0;
            end else begin
               o_output_ext_mute_n[g]       <= ~out_ctrl[g].ext_mute;
               o_output_route[g].source_sel <= out_ctrl[g].source_sel;
               o_output_route[g].valid      <= (out_ctrl[g].source_sel != 3'h0);
            end
         end

         a_mute_pin_level: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
            (i_reg_wr && out_reg_hit(i_reg_addr, g))
            |=> ##1 (o_output_ext_mute_n[g] == !$past(i_reg_wdata[`CCRL_BIT_EXT_MUTE], 2)))
            else $error("mute pin does not follow its register bit");
         a_route_reserved: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
            (out_ctrl[g].source_sel == 3'h0) |=> !o_output_route[g].valid)
            else $error("reserved source code marked valid");
      end
   endgenerate

   // read port: unmapped offsets and reserved bits read zero
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `CCRL_OFS_DAC2_CTRL:  o_reg_rdata <= dac2_ctrl;
            `CCRL_OFS_OUT1:       o_reg_rdata <= out_ctrl[0];
            `CCRL_OFS_OUT2:       o_reg_rdata <= out_ctrl[1];
            `CCRL_OFS_OUT3:       o_reg_rdata <= out_ctrl[2];
            `CCRL_OFS_ADC_LEFT:   o_reg_rdata <= adc_vol[0];
            `CCRL_OFS_ADC_RIGHT:  o_reg_rdata <= adc_vol[1];
            `CCRL_OFS_DAC2_VOL_A: o_reg_rdata <= dac2_vol[0];
            `CCRL_OFS_DAC2_VOL_B: o_reg_rdata <= dac2_vol[1];
            default:              o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // loopback switches the first DAC port source; registered so the pins see no glitch
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_dac1_port <= '0;
      end else begin
         o_dac1_port <= dac2_ctrl.loopback_en ? i_adc_port : i_dac1_pins;
      end
   end

   // frame edge marks a new sample pair
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         frame_prev <= 1'b0;
      end else begin
         frame_prev <= i_frame_clock;
      end
   end
   assign tick = i_frame_clock && !frame_prev;

   // mixing then polarity inversion
   always_comb begin
      sum_lr = (SAMPLE_W+1)'(i_dac2_left) + (SAMPLE_W+1)'(i_dac2_right);
      mono   = sum_lr[SAMPLE_W:1];
      unique case (dac2_ctrl.second_dac_mixer_sel)
         ccrl_pkg::CCRL_MIX_STEREO: begin
            next_a = i_dac2_left;
            next_b = i_dac2_right;
         end
         ccrl_pkg::CCRL_MIX_MONO, ccrl_pkg::CCRL_MIX_MONO_B: begin
            next_a = mono;
            next_b = mono;
         end
         ccrl_pkg::CCRL_MIX_SWAP: begin
            next_a = i_dac2_right;
            next_b = i_dac2_left;
         end
      endcase
      if (dac2_ctrl.second_dac_invert) begin
         next_a = negate(next_a);
         next_b = negate(next_b);
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_dac2_a <= '0;
         o_dac2_b <= '0;
      end else if (tick) begin
         o_dac2_a <= next_a;
         o_dac2_b <= next_b;
      end
   end

   // crossings are judged per channel against that channel's last sample
   assign chan_cross = {2'b00, crossed(o_dac2_b, next_b), crossed(o_dac2_a, next_a)};

   // ADC targets hold on reserved codes
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         adc_target[0] <= '0;
         adc_target[1] <= '0;
      end else begin
         if (adc_code_ok(adc_vol[0])) adc_target[0] <= adc_decode(adc_vol[0]);
         if (adc_code_ok(adc_vol[1])) adc_target[1] <= adc_decode(adc_vol[1]);
      end
   end

   // channels 0/1: second DAC A/B, 2/3: ADC left/right, all in signed 1/8 dB
   always_comb begin
      chan_target[0] = -LEVEL_W'({dac2_vol[0], 2'b00});
      chan_target[1] = dac2_ctrl.second_dac_single_volume ? chan_target[0]
                                                          : -LEVEL_W'({dac2_vol[1], 2'b00});
      chan_target[2] = adc_target[0];
      chan_target[3] = adc_target[1];
   end
   assign chan_soft = {{2{i_adc_soft_ramp_en}}, {2{dac2_ctrl.second_dac_soft_ramp_en}}};
   assign chan_zc   = {2'b00, {2{dac2_ctrl.second_dac_zero_cross_en}}};

   generate
      for (g = 0; g < 4; g++) begin : g_chan
         ccrl_level_ramp #(
            .LEVEL_W (LEVEL_W),
            .TIMEOUT (ZC_TIMEOUT)
         ) u_ramp (
            .i_clk_sys    (i_clk_sys),
            .i_sys_rst    (i_sys_rst),
            .i_soft       (chan_soft[g]),
            .i_zc         (chan_zc[g]),
            .i_tick       (tick),
            .i_zero_cross (chan_cross[g]),
            .i_target     (chan_target[g]),
            .o_level      (chan_level[g])
         );
      end
   endgenerate

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_dac2_level_a    <= '0;
         o_dac2_level_b    <= '0;
         o_adc_level_left  <= '0;
         o_adc_level_right <= '0;
      end else begin
         o_dac2_level_a    <= chan_level[0];
         o_dac2_level_b    <= chan_level[1];
         o_adc_level_left  <= chan_level[2];
         o_adc_level_right <= chan_level[3];
      end
   end

   // checked at the level outputs so a broken link or a broken B engine both show up
   a_single_vol_link: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (dac2_ctrl.second_dac_single_volume && !dac2_ctrl.second_dac_soft_ramp_en
       && !dac2_ctrl.second_dac_zero_cross_en)
      |=> ##1 (o_dac2_level_b == o_dac2_level_a))
      else $error("channel B does not follow channel A volume");
   a_loopback_route: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      dac2_ctrl.loopback_en |=> (o_dac1_port == $past(i_adc_port)))
      else $error("loopback does not carry the ADC port");
   a_mixer_swap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (tick && !dac2_ctrl.second_dac_invert
       && dac2_ctrl.second_dac_mixer_sel == ccrl_pkg::CCRL_MIX_SWAP)
      |=> (o_dac2_a == $past(i_dac2_right)) && (o_dac2_b == $past(i_dac2_left)))
      else $error("swap mix does not exchange channels");
   a_polarity_invert: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (tick && dac2_ctrl.second_dac_invert && i_dac2_left != '0
       && dac2_ctrl.second_dac_mixer_sel == ccrl_pkg::CCRL_MIX_STEREO)
      |=> (o_dac2_a[SAMPLE_W-1] != $past(i_dac2_left[SAMPLE_W-1])))
      else $error("inverted sample kept its sign");
   a_mono_equal: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (tick && dac2_ctrl.second_dac_mixer_sel[0] != dac2_ctrl.second_dac_mixer_sel[1])
      |=> (o_dac2_a == o_dac2_b))
      else $error("mono mix produced different outputs");

   c_loopback_on: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(dac2_ctrl.loopback_en));
   c_mute_engaged: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $fell(o_output_ext_mute_n[0]));
   c_soft_zc_both: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      dac2_ctrl.second_dac_soft_ramp_en && dac2_ctrl.second_dac_zero_cross_en
      && (o_dac2_level_a != chan_target[0]));
endmodule // ccrl_top

//--- ccrl_host.sv
// host controller model driving the control port at the falling edge
`timescale 1ns/10ps
module ccrl_host (
   // clock and read data
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   // control port strobes and buses
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'hff;
      o_wdata = 8'hff;
   end
   // released buses show the inverse of the last value, never a stale copy
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      @(negedge i_clk);
      d = i_rdata;
   endtask
endmodule // ccrl_host

//--- tb.sv
// self-checking bench of the level/route control block
`timescale 1ns/10ps
module tb;
   localparam int TMO = 512;
   logic                     clk = 1'b0, rst = 1'b1, wr, rd, fclk = 1'b0, adc_soft = 1'b0;
   logic [7:0]               addr, wdata, rdata, d;
   logic signed [23:0]       sl = '0, sr = '0, oa, ob, l, r;
   logic signed [10:0]       la, lb, al, ar;
   ccrl_pkg::ccrl_serial_s   adc_p = '0, pins = '0, dport;
   logic [2:0]               mute_n;
   ccrl_pkg::ccrl_route_s [2:0] route;
   int                       num_errors = 0, checked = 0;
   logic [7:0]               ra [9] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h14,
                                        8'h15, 8'h13};
   logic [7:0]               vc [5] = '{8'h18, 8'h00, 8'hff, 8'h58, 8'h40};
   logic [23:0]              ve [5] = '{24'd96, 24'd0, -24'sd4, -24'sd672, -24'sd672};
   always #2 clk = ~clk;
   ccrl_host host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
                   .o_wdata(wdata));
   ccrl_top #(.ZC_TIMEOUT(TMO)) dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_adc_soft_ramp_en(adc_soft), .i_frame_clock(fclk), .i_dac2_left(sl), .i_dac2_right(sr),
      .o_dac2_a(oa), .o_dac2_b(ob), .o_dac2_level_a(la), .o_dac2_level_b(lb),
      .o_adc_level_left(al), .o_adc_level_right(ar), .i_adc_port(adc_p), .i_dac1_pins(pins),
      .o_dac1_port(dport), .o_output_ext_mute_n(mute_n), .o_output_route(route));
   task automatic chk_val(logic [23:0] g, logic [23:0] e);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_reg(logic [7:0] g, logic [7:0] e);
      chk_val({16'h0, g}, {16'h0, e});
   endtask
   task automatic rdc(logic [7:0] a, logic [7:0] e);
      logic [7:0] v;
      host.rd(a, v);
      chk_reg(v, e);
   endtask
   task automatic frm(logic [23:0] fl, logic [23:0] fr);
      @(negedge clk);
      sl = fl;
      sr = fr;
      fclk = 1'b1;
      @(negedge clk);
      fclk = 1'b0;
      @(negedge clk);
   endtask
   // levels land one cycle behind the internal level, so let two edges pass
   task automatic lv(logic [23:0] ea, logic [23:0] eb);
      repeat (2) @(negedge clk);
      chk_val(la, ea);
      chk_val(lb, eb);
   endtask
   function automatic logic [23:0] pos();
      return 24'(($urandom & 32'h3fffff) | 32'h1);
   endfunction
   function automatic logic [23:0] ng(logic signed [23:0] x);
      return (x == 24'sh800000) ? 24'h7fffff : -x;
   endfunction
   task close_out;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      close_out();
   end
   initial begin
      logic signed [24:0] s;
      logic signed [23:0] ea, eb;
      void'($urandom(32'h8cf6e133));
      repeat (5) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      for (int i = 0; i < 9; i++) rdc(ra[i], (i inside {1, 2, 3}) ? 8'h07 : 8'h00);
      chk_reg({5'h0, mute_n}, 8'h07);
      chk_reg({4'h0, route[2]}, 8'h0f);
      for (int j = 0; j < 6; j++) begin
         d = (j == 0) ? 8'h08 : (j == 1) ? 8'hff : 8'($urandom);
         host.wr(8'h0d + 8'(j % 3), d);
         repeat (2) @(negedge clk);
         chk_reg({7'h0, mute_n[j % 3]}, {7'h0, ~d[3]});
         chk_reg({4'h0, route[j % 3]}, {4'h0, |d[2:0], d[2:0]});
         rdc(8'h0d + 8'(j % 3), d & 8'h0f);
      end
      for (int i = 0; i < 5; i++) begin
         host.wr(8'h10, vc[i]);
         host.wr(8'h11, vc[i]);
         repeat (3) @(negedge clk);
         chk_val(al, ve[i]);
         chk_val(ar, ve[i]);
      end
      rdc(8'h11, 8'h40);
      host.wr(8'h14, 8'h10);
      host.wr(8'h15, 8'h03);
      lv(-24'sd64, -24'sd12);
      host.wr(8'h0c, 8'h40);
      lv(-24'sd64, -24'sd64);
      host.wr(8'h0c, 8'h00);
      lv(-24'sd64, -24'sd12);
      host.wr(8'h0c, 8'h20);
      host.wr(8'h14, 8'h11);
      for (int i = 0; i < 3; i++) begin
         repeat (2) frm(pos(), pos());
         lv((i == 0) ? -24'sd66 : -24'sd68, -24'sd12);
      end
      host.wr(8'h0c, 8'h10);
      host.wr(8'h14, 8'h00);
      host.wr(8'h15, 8'h00);
      repeat (3) frm(pos(), pos());
      lv(-24'sd68, -24'sd12);
      frm(ng(pos()), pos());
      lv(24'd0, -24'sd12);
      repeat (TMO - 16) frm(ng(pos()), pos());
      lv(24'd0, -24'sd12);
      repeat (24) frm(ng(pos()), pos());
      lv(24'd0, 24'd0);
      host.wr(8'h0c, 8'h30);
      host.wr(8'h14, 8'h01);
      frm(pos(), ng(pos()));
      lv(-24'sd1, 24'd0);
      frm(pos(), ng(pos()));
      lv(-24'sd1, 24'd0);
      for (int k = 0; k < 8; k++) begin
         host.wr(8'h0c, 8'(k));
         l = 24'($urandom);
         r = 24'($urandom);
         frm(l, r);
         s = l + r;
         ea = (k[1:0] == 2'b00) ? l : (k[1:0] == 2'b11) ? r : s[24:1];
         eb = (k[1:0] == 2'b00) ? r : (k[1:0] == 2'b11) ? l : s[24:1];
         chk_val(oa, k[2] ? ng(ea) : ea);
         chk_val(ob, k[2] ? ng(eb) : eb);
      end
      for (int k = 0; k < 6; k++) begin
         if (k == 0) host.wr(8'h0c, 8'h08);
         if (k == 3) host.wr(8'h0c, 8'h00);
         @(negedge clk);
         adc_p = 3'($urandom);
         pins = ~adc_p;
         repeat (2) @(negedge clk);
         chk_reg({5'h0, dport}, {5'h0, (k < 3) ? adc_p : pins});
      end
      // adc soft ramp: 0 dB down to -0.5 dB target, two frames give two 1/8 dB steps
      host.wr(8'h10, 8'h00);
      repeat (3) @(negedge clk);
      chk_val(al, 24'd0);
      adc_soft = 1'b1;
      host.wr(8'h10, 8'hff);
      repeat (2) frm(pos(), pos());
      chk_val(al, -24'sd2);
      chk_val(ar, -24'sd672);
      host.wr(8'h13, 8'haa);
      rdc(8'h13, 8'h00);
      close_out();
   end
endmodule // tb
